// ==== ast_pkg.sv ====
// constants for the async serial transceiver: register map, fields, reset values, timing
// assumes an 8-bit register port and a single 100 MHz core clock
`default_nettype none
package ast_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] STATUS_OFS = 3'h0;
	localparam logic [2:0] DATA_OFS   = 3'h1;
	localparam logic [2:0] CTRL1_OFS  = 3'h2;
	localparam logic [2:0] CTRL2_OFS  = 3'h3;
	localparam logic [2:0] BAUD_OFS   = 3'h4;
	// status_port bits
	localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
	localparam int ST_TC   = 6;
	localparam int ST_RX_FULL_FLAG = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OVR  = 3;
	localparam int ST_NF   = 2;
	localparam int ST_FE   = 1;
	// control_one bits
	localparam int C1_R8 = 7;
	localparam int C1_T8 = 6;
	localparam int C1_M  = 4;
	// control_two bits
	localparam int C2_TIE  = 7;
	localparam int C2_TX_DONE_IRQ_EN = 6;
	localparam int C2_RIE  = 5;
	localparam int C2_IDLE_IRQ_EN = 4;
	localparam int C2_TE   = 3;
	localparam int C2_RE   = 2;
	localparam int C2_SBK  = 0;
	// baud_select fields: coarse prescaler, tx and rx power-of-two dividers
	localparam int BS_PR_HI = 7;
	localparam int BS_PR_LO = 6;
	localparam int BS_TR_HI = 5;
	localparam int BS_TR_LO = 3;
	localparam int BS_RR_HI = 2;
	localparam int BS_RR_LO = 0;
	localparam logic [3:0] PR_VAL0 = 4'h1;
	localparam logic [3:0] PR_VAL1 = 4'h3;
	localparam logic [3:0] PR_VAL2 = 4'h4;
	localparam logic [3:0] PR_VAL3 = 4'hd;
	// reset values
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] BAUD_RST  = 8'h00;
	// frame timing
	localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
	localparam logic [4:0] SAMPLE_A        = 5'h08;
	localparam logic [4:0] SAMPLE_C        = 5'h0a;
	localparam logic [3:0] FRAME_LEN8      = 4'ha;
	localparam logic [3:0] FRAME_LEN9      = 4'hb;
	localparam logic [3:0] MARK_BIT_LEN    = 4'h1;
	localparam logic [3:0] SUB_LAST        = 4'hf;
endpackage
`default_nettype wire

// ==== ast_transceiver.sv ====
// async serial transceiver: tx path with holding buffer, x16 oversampled rx path, register port
// assumes the host keeps to the status-then-data access sequences and one strobe per cycle
//
// Contract
// - idle line high; pin released when disabled
// - start, 8 or 9 bits lsb first, stop
// - start bit low, stop bit high
// - ninth tx bit from control field
// - idle frame ones, break frame zeros
// - repeat breaks, then one mark bit
// - tx enable sends idle frame first
// - tx enable toggle: idle frame, drop buffer
// - busy write goes to holding buffer
// - idle write loads shifter, sets empty flag
// - buffer empty interrupt when enabled, unmasked
// - done flag and interrupt after stop
// - status access then data write clears
// - ninth rx bit into control field
// - rx enable starts start-bit search
// - completed char to buffer, full flag
// - status then data read clears full
// - overrun keeps buffer, flags, interrupts
// - overrun cleared by status, data read
// - idle frame detected raises idle interrupt
// - received break is a framing error
// - noise unless samples 8,9,10 agree
// - noise cleared by status, data read
// - false start discarded, noise held hidden
// - frame error flagged, data still moved
// - 16 samples, majority of 8,9,10
// - independent tx/rx baud dividers
`timescale 1ns/100ps
`default_nettype none
module ast_transceiver
	import ast_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// processor interface
	input  wire logic       cpu_irq_mask,
	output logic            irq,
	// serial pins
	output logic            serial_tx_pin,
	output logic            serial_tx_oe_n,
	input  wire logic       serial_rx_pin
);
	typedef enum logic [3:0] {
		TX_QUIET = 4'b0001,
		TX_DATA  = 4'b0010,
		TX_BRK   = 4'b0100,
		TX_MARK  = 4'b1000
	} ast_tx_type;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_BUSY = 2'b10
	} ast_rx_type;

	typedef struct packed {
		logic [7:0]  rdata;
		logic [7:0]  ctrl2;
		logic        word9;
		logic        tx_ninth_bit;
		logic        rx_ninth_bit;
		logic [7:0]  baud;
		logic        tx_buffer_empty_flag;
		logic        tc;
		logic        rx_full_flag;
		logic        idle;
		logic        ovr;
		logic        nf;
		logic        fe;
		logic        seen;
		logic [7:0]  tx_holding_buffer;
		logic        tdr_full;
		logic        idle_pend;
		logic        te_q;
		logic        re_q;
		ast_tx_type  tx_st;
		logic [10:0] tx_shift;
		logic [3:0]  tx_left;
		logic [3:0]  tx_sub;
		logic [10:0] tx_cnt;
		logic [10:0] rx_cnt;
		logic [1:0]  rx_sync;
		logic        rx_prev;
		ast_rx_type  rx_st;
		logic [4:0]  samp;
		logic [2:0]  vote;
		logic [3:0]  bitn;
		logic [8:0]  rx_shift;
		logic        noise_acc;
		logic        hidden_nf;
		logic [8:0]  rx_holding_buffer;
		logic [7:0]  idle_cnt;
		logic        idle_arm;
	} ast_state_type;

	ast_state_type st;
	ast_state_type next_st;

	logic        te;
	logic        re;
	logic        send_break;
	logic [3:0]  pr_val;
	logic [10:0] tx_div;
	logic [10:0] rx_div;
	logic        tx_tick;
	logic        rx_tick;
	logic        tx_end;
	logic        frame_end;
	logic        launch;
	logic        direct;
	logic        maj;
	logic        noisy;
	logic        rx_s;
	logic [3:0]  flen;
	logic [7:0]  idle_len;
	logic        char_done;
	logic        idle_evt;
	logic        wr_data;
	logic        rd_data;

	assign te       = st.ctrl2[C2_TE];
	assign re       = st.ctrl2[C2_RE];
	assign send_break      = st.ctrl2[C2_SBK];
	assign flen     = st.word9 ? FRAME_LEN9 : FRAME_LEN8;
	assign idle_len = {flen, 4'h0};
	assign rx_s     = st.rx_sync[1];
	assign wr_data  = reg_wr && (reg_addr == DATA_OFS);
	assign rd_data  = reg_rd && (reg_addr == DATA_OFS);

	// coarse prescaler times power-of-two divider
	always_comb begin
		unique case (st.baud[BS_PR_HI:BS_PR_LO])
			2'b00: pr_val = PR_VAL0;
			2'b01: pr_val = PR_VAL1;
			2'b10: pr_val = PR_VAL2;
			2'b11: pr_val = PR_VAL3;
		endcase
	end
	assign tx_div  = 11'({7'h00, pr_val} << st.baud[BS_TR_HI:BS_TR_LO]);
	assign rx_div  = 11'({7'h00, pr_val} << st.baud[BS_RR_HI:BS_RR_LO]);
	assign tx_tick = (st.tx_cnt == tx_div - 11'h001);
	assign rx_tick = (st.rx_cnt == rx_div - 11'h001);

	assign tx_end    = (st.tx_st != TX_QUIET) && tx_tick && (st.tx_sub == SUB_LAST);
	assign frame_end = tx_end && (st.tx_left == MARK_BIT_LEN);
	assign launch    = te && ((st.tx_st == TX_QUIET) || frame_end);
	assign direct    = wr_data && te && st.te_q && (st.tx_st == TX_QUIET) && !send_break && !st.idle_pend;

	assign maj   = (st.vote[0] & st.vote[1]) | (st.vote[0] & st.vote[2]) | (st.vote[1] & st.vote[2]);
	assign noisy = !((st.vote[0] == st.vote[1]) && (st.vote[1] == st.vote[2]));

	assign char_done = (st.rx_st == RX_BUSY) && rx_tick && (st.samp == SAMPLES_PER_BIT)
		&& (st.bitn == flen - 4'h1);
	assign idle_evt  = re && (st.rx_st == RX_IDLE) && rx_tick && st.idle_arm && rx_s
		&& (st.idle_cnt == idle_len - 8'h01);

	always_comb begin
		next_st = st;
		next_st.rx_sync = {st.rx_sync[0], serial_rx_pin};
		next_st.te_q    = te;
		next_st.re_q    = re;
		next_st.tx_cnt  = tx_tick ? 11'h000 : st.tx_cnt + 11'h001;
		next_st.rx_cnt  = rx_tick ? 11'h000 : st.rx_cnt + 11'h001;

		// register port
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				STATUS_OFS: next_st.rdata = {st.tx_buffer_empty_flag, st.tc, st.rx_full_flag, st.idle, st.ovr, st.nf, st.fe, 1'b0};
				DATA_OFS:   next_st.rdata = st.rx_holding_buffer[7:0];
				CTRL1_OFS:  next_st.rdata = {st.rx_ninth_bit, st.tx_ninth_bit, 1'b0, st.word9, 4'h0};
				CTRL2_OFS:  next_st.rdata = st.ctrl2;
				BAUD_OFS:   next_st.rdata = st.baud;
				default:    next_st.rdata = 8'h00;
			endcase
		end
		if (reg_rd && (reg_addr == STATUS_OFS))
			next_st.seen = 1'b1;
		if (reg_wr) begin
			unique case (reg_addr)
				CTRL1_OFS: begin
					next_st.tx_ninth_bit = reg_wdata[C1_T8];
					next_st.word9        = reg_wdata[C1_M];
				end
				CTRL2_OFS: next_st.ctrl2 = reg_wdata;
				BAUD_OFS:  next_st.baud  = reg_wdata;
				default:   next_st.ctrl2 = st.ctrl2;
			endcase
		end
		if (wr_data) begin
			next_st.seen = 1'b0;
			if (st.seen) begin
				next_st.tx_buffer_empty_flag = 1'b0;
				next_st.tc   = 1'b0;
			end
			if (!direct) begin
				next_st.tx_holding_buffer      = reg_wdata;
				next_st.tdr_full = 1'b1;
			end
		end
		if (rd_data) begin
			next_st.seen = 1'b0;
			if (st.seen) begin
				next_st.rx_full_flag = 1'b0;
				next_st.ovr  = 1'b0;
				next_st.nf   = 1'b0;
				next_st.fe   = 1'b0;
				next_st.idle = 1'b0;
			end
		end

		// transmitter enable edge: idle frame next, holding buffer dropped
		if (te && !st.te_q) begin
			next_st.idle_pend = 1'b1;
			next_st.tdr_full  = 1'b0;
			next_st.tx_buffer_empty_flag      = 1'b1;
		end

		// bit timing inside a frame
		if ((st.tx_st != TX_QUIET) && tx_tick) begin
			next_st.tx_sub = st.tx_sub + 4'h1;
			if (tx_end) begin
				next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
				next_st.tx_left  = st.tx_left - 4'h1;
			end
		end
		if (frame_end)
			next_st.tx_st = TX_QUIET;

		// next frame choice at a frame boundary
		if (launch && te && st.te_q) begin
			next_st.tx_sub = 4'h0;
			if (send_break) begin
				next_st.tx_st    = TX_BRK;
				next_st.tx_shift = 11'h000;
				next_st.tx_left  = flen;
			end else if (frame_end && (st.tx_st == TX_BRK)) begin
				next_st.tx_st    = TX_MARK;
				next_st.tx_shift = 11'h7ff;
				next_st.tx_left  = MARK_BIT_LEN;
			end else if (st.idle_pend) begin
				next_st.tx_st     = TX_MARK;
				next_st.tx_shift  = 11'h7ff;
				next_st.tx_left   = flen;
				next_st.idle_pend = 1'b0;
			end else if (st.tdr_full) begin
				next_st.tx_st    = TX_DATA;
				next_st.tx_shift = {1'b1, st.word9 ? st.tx_ninth_bit : 1'b1, st.tx_holding_buffer, 1'b0};
				next_st.tx_left  = flen;
				next_st.tdr_full = 1'b0;
				next_st.tx_buffer_empty_flag     = 1'b1;
			end else if (direct) begin
				next_st.tx_st    = TX_DATA;
				next_st.tx_shift = {1'b1, st.word9 ? st.tx_ninth_bit : 1'b1, reg_wdata, 1'b0};
				next_st.tx_left  = flen;
				next_st.tx_buffer_empty_flag     = 1'b1;
			end else if (frame_end) begin
				next_st.tc = 1'b1;
			end
		end else if (frame_end) begin
			next_st.tc = 1'b1;
		end

		// receiver
		if (re && !st.re_q)
			next_st.idle_arm = 1'b1;
		if (rx_tick) begin
			next_st.rx_prev = rx_s;
			unique case (st.rx_st)
				RX_IDLE: begin
					next_st.idle_cnt = (rx_s && (st.idle_cnt != idle_len)) ? st.idle_cnt + 8'h01 : 8'h00;
					if (idle_evt) begin
						next_st.idle     = 1'b1;
						next_st.idle_arm = 1'b0;
					end
					if (re && st.rx_prev && !rx_s) begin
						next_st.rx_st     = RX_BUSY;
						next_st.samp      = 5'h01;
						next_st.bitn      = 4'h0;
						next_st.noise_acc = 1'b0;
					end
				end
				RX_BUSY: begin
					next_st.samp = st.samp + 5'h01;
					if ((st.samp >= SAMPLE_A - 5'h01) && (st.samp <= SAMPLE_C - 5'h01))
						next_st.vote = {st.vote[1:0], rx_s};
					if (st.samp == SAMPLES_PER_BIT) begin
						next_st.samp      = 5'h01;
						next_st.bitn      = st.bitn + 4'h1;
						next_st.noise_acc = st.noise_acc | noisy;
						if ((st.bitn == 4'h0) && maj) begin
							next_st.rx_st     = RX_IDLE;
							next_st.hidden_nf = 1'b1;
						end else if ((st.bitn != 4'h0) && !char_done) begin
							next_st.rx_shift = {maj, st.rx_shift[8:1]};
						end
					end
					if (char_done) begin
						next_st.rx_st    = RX_IDLE;
						next_st.idle_arm = 1'b1;
						next_st.idle_cnt = 8'h00;
						if (st.rx_full_flag && !(rd_data && st.seen)) begin
							next_st.ovr = 1'b1;
						end else begin
							next_st.rx_holding_buffer          = st.word9 ? st.rx_shift : {1'b0, st.rx_shift[8:1]};
							next_st.rx_ninth_bit = st.word9 & st.rx_shift[8];
							next_st.rx_full_flag         = 1'b1;
							next_st.nf           = st.noise_acc | noisy | st.hidden_nf;
							next_st.fe           = !maj;
							next_st.hidden_nf    = 1'b0;
						end
					end
				end
			endcase
		end
		if (!re)
			next_st.rx_st = RX_IDLE;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st              <= '0;
			st.ctrl2        <= CTRL2_RST;
			st.word9        <= CTRL1_RST[C1_M];
			st.baud         <= BAUD_RST;
			st.tx_buffer_empty_flag         <= 1'b1;
			st.tc           <= 1'b1;
			st.tx_st        <= TX_QUIET;
			st.tx_shift     <= 11'h7ff;
			st.rx_sync      <= 2'b11;
			st.rx_prev      <= 1'b1;
			st.rx_st        <= RX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata      = st.rdata;
	assign serial_tx_pin  = (st.tx_st == TX_QUIET) ? 1'b1 : st.tx_shift[0];
	assign serial_tx_oe_n = !(te || re);
	assign irq = !cpu_irq_mask && ((st.tx_buffer_empty_flag && st.ctrl2[C2_TIE])
		|| (st.tc && st.ctrl2[C2_TX_DONE_IRQ_EN])
		|| ((st.rx_full_flag || st.ovr) && st.ctrl2[C2_RIE])
		|| (st.idle && st.ctrl2[C2_IDLE_IRQ_EN]));

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_status_read;
		reg_rd && (reg_addr == STATUS_OFS);
	endsequence
	sequence s_data_read;
		reg_rd && (reg_addr == DATA_OFS) && !char_done;
	endsequence
	sequence s_data_write;
		reg_wr && (reg_addr == DATA_OFS) && !frame_end && !launch;
	endsequence

	a_line_idle_high: assert property ((st.tx_st == TX_QUIET) |-> serial_tx_pin)
		else $error("tx line not high while quiet");
	a_pin_release: assert property (!(te || re) |-> serial_tx_oe_n)
		else $error("tx pin driven while disabled");
	a_start_low: assert property ((st.tx_st == TX_DATA) && (st.tx_left == flen) |-> !serial_tx_pin)
		else $error("start bit not low");
	a_break_low: assert property ((st.tx_st == TX_BRK) |-> !serial_tx_pin)
		else $error("break frame not low");
	a_direct_empty: assert property (direct |=> st.tx_buffer_empty_flag && (st.tx_st == TX_DATA))
		else $error("direct load did not set empty flag");
	a_tx_seq_clear: assert property (s_status_read ##1 s_data_write |=> !st.tc)
		else $error("done flag not cleared by sequence");
	a_rx_seq_clear: assert property (s_status_read ##1 s_data_read |=> !st.rx_full_flag && !st.ovr)
		else $error("full flag not cleared by sequence");
	a_rx_full_set: assert property (char_done && !st.rx_full_flag |=> st.rx_full_flag)
		else $error("full flag not set on char");
	a_overrun_keep: assert property (char_done && st.rx_full_flag && !rd_data |=> st.ovr && $stable(st.rx_holding_buffer))
		else $error("overrun lost buffer or flag");
	a_irq_masked: assert property (cpu_irq_mask |-> !irq)
		else $error("irq while masked");
	a_done_after_stop: assert property (frame_end && !send_break && !st.idle_pend && !st.tdr_full
		&& (st.tx_st != TX_BRK) |=> st.tc)
		else $error("done flag not set after stop");
endmodule // ast_transceiver
`default_nettype wire

// ==== ast_peer.sv ====
// far-side serial peer: decodes the transmit line, sends frames on the receive line
// assumes baud_select at reset value, so one bit is 16 core cycles
`timescale 1ns/100ps
`default_nettype none
module ast_peer (
	// clock
	input  wire logic core_clk,
	// serial lines and 9-bit frame select
	input  wire logic tx_line,
	input  wire logic word9,
	output logic      rx_line
);
	logic [8:0] got_word = 9'h000;
	logic       got_stop = 1'b0;
	int         got_cnt  = 0;
	initial rx_line = 1'b1;
	// decode: mid-bit samples after the start edge
	always begin : dec
		logic [9:0] w;
		@(negedge tx_line);
		repeat (8) @(posedge core_clk);
		w = 10'h000;
		for (int i = 0; i < 9 + word9; i++) begin
			repeat (16) @(posedge core_clk);
			w[i] = tx_line;
		end
		got_stop = word9 ? w[9] : w[8];
		got_word = word9 ? w[8:0] : {1'b0, w[7:0]};
		got_cnt++;
	end
	// frame out, line back high after; nz flips the 10th and 11th samples of data bit 2
	task automatic send(input logic [8:0] w, input logic stop, input logic nz);
		logic [11:0] f;
		f = word9 ? {1'b1, stop, w, 1'b0} : {2'b11, stop, w[7:0], 1'b0};
		for (int i = 0; i < 12; i++) begin
			rx_line <= f[i];
			repeat (9) @(posedge core_clk);
			if (nz && i == 3)
				rx_line <= ~f[i];
			repeat (2) @(posedge core_clk);
			rx_line <= f[i];
			repeat (5) @(posedge core_clk);
		end
	endtask
	// short low pulse, too short to pass as a start bit
	task automatic glitch();
		rx_line <= 1'b0;
		repeat (4) @(posedge core_clk);
		rx_line <= 1'b1;
		repeat (40) @(posedge core_clk);
	endtask
endmodule // ast_peer
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the transceiver, one task per scenario
// assumes the peer model on the serial lines and baud_select at reset value
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("unexpected at %0t: %h vs %h", $time, g, e); \
	end \
end
module testbench
	import ast_pkg::*;
;
	logic       core_clk     = 1'b0;
	logic       rst_n        = 1'b0;
	logic [2:0] reg_addr     = 3'h0;
	logic [7:0] reg_wdata    = 8'h00;
	logic       reg_wr       = 1'b0;
	logic       reg_rd       = 1'b0;
	logic       cpu_irq_mask = 1'b0;
	logic       word9        = 1'b0;
	logic [7:0] reg_rdata;
	logic       irq;
	logic       serial_tx_pin;
	logic       serial_tx_oe_n;
	wire logic  serial_rx_pin;
	int         error_cnt    = 0;
	int         n_checks     = 0;
	int         cycles       = 0;
	ast_transceiver dut_u (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.cpu_irq_mask   (cpu_irq_mask),
		.irq            (irq),
		.serial_tx_pin  (serial_tx_pin),
		.serial_tx_oe_n (serial_tx_oe_n),
		.serial_rx_pin  (serial_rx_pin)
	);
	ast_peer peer_u (
		.core_clk (core_clk),
		.tx_line  (serial_tx_pin),
		.word9    (word9),
		.rx_line  (serial_rx_pin)
	);
	always #5 core_clk = ~core_clk;
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic ck(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		`CHK(v & m, e)
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 3000 && peer_u.got_cnt < n; i++)
			@(posedge core_clk);
	endtask
	task automatic hold(input logic lv, output int n);
		n = 0;
		while (serial_tx_pin === lv && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask
	task automatic t_reset();
		`CHK({serial_tx_pin, serial_tx_oe_n, irq}, 3'b110)
		ck(STATUS_OFS, 8'hff, 8'hc0);
		ck(3'h7, 8'hff, 8'h00);
		ck(CTRL2_OFS, 8'hff, CTRL2_RST);
	endtask
	task automatic t_tx();
		int         n;
		logic [7:0] v;
		wr(CTRL2_OFS, 8'h0c);
		`CHK(serial_tx_oe_n, 1'b0)
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'ha5);
		ck(STATUS_OFS, 8'hc0, 8'h00);
		hold(1'b1, n);
		`CHK(n > 140 && n < 170, 1'b1)
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'h3c);
		wait_got(1);
		`CHK({peer_u.got_stop, peer_u.got_word}, 10'h2a5)
		wait_got(2);
		`CHK({peer_u.got_stop, peer_u.got_word}, 10'h23c)
		repeat (30) @(posedge core_clk);
		ck(STATUS_OFS, 8'hc0, 8'hc0);
		wr(CTRL2_OFS, 8'h4c);
		`CHK(irq, 1'b1)
		wr(CTRL2_OFS, 8'h8c);
		`CHK(irq, 1'b1)
		@(posedge core_clk);
		cpu_irq_mask <= 1'b1;
		#1;
		`CHK(irq, 1'b0)
		wr(CTRL2_OFS, 8'h0c);
		cpu_irq_mask <= 1'b0;
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'h81);
		repeat (3) @(posedge core_clk);
		#1;
		`CHK(serial_tx_pin, 1'b0)
		ck(STATUS_OFS, 8'hc0, 8'h80);
		wait_got(3);
		`CHK(peer_u.got_word, 9'h081)
	endtask
	task automatic t_tx9_break();
		int         n;
		logic [7:0] v;
		repeat (20) @(posedge core_clk);
		wr(CTRL1_OFS, 8'h50);
		word9 <= 1'b1;
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'h12);
		wait_got(4);
		`CHK(peer_u.got_word, 9'h112)
		repeat (20) @(posedge core_clk);
		wr(CTRL1_OFS, 8'h00);
		word9 <= 1'b0;
		wr(CTRL2_OFS, 8'h0d);
		repeat (4) @(posedge core_clk);
		hold(1'b0, n);
		`CHK(n, 400)
		wr(CTRL2_OFS, 8'h0c);
		hold(1'b0, n);
		`CHK(n < 180, 1'b1)
		repeat (8) @(posedge core_clk);
		`CHK(serial_tx_pin, 1'b1)
		`CHK(peer_u.got_stop, 1'b0)
	endtask
	task automatic t_rx();
		wr(CTRL2_OFS, 8'h2c);
		@(posedge core_clk);
		peer_u.send(9'h05a, 1'b1, 1'b0);
		`CHK(irq, 1'b1)
		ck(STATUS_OFS, 8'h2e, 8'h20);
		ck(DATA_OFS, 8'hff, 8'h5a);
		ck(STATUS_OFS, 8'h20, 8'h00);
		`CHK(irq, 1'b0)
		peer_u.send(9'h011, 1'b1, 1'b0);
		peer_u.send(9'h022, 1'b1, 1'b0);
		ck(STATUS_OFS, 8'h28, 8'h28);
		`CHK(irq, 1'b1)
		ck(DATA_OFS, 8'hff, 8'h11);
		ck(STATUS_OFS, 8'h28, 8'h00);
	endtask
	task automatic t_rx_err();
		wr(CTRL1_OFS, 8'h10);
		word9 <= 1'b1;
		@(posedge core_clk);
		peer_u.send(9'h1c3, 1'b1, 1'b0);
		ck(STATUS_OFS, 8'h26, 8'h20);
		ck(CTRL1_OFS, 8'h80, 8'h80);
		ck(DATA_OFS, 8'hff, 8'hc3);
		wr(CTRL1_OFS, 8'h00);
		word9 <= 1'b0;
		@(posedge core_clk);
		peer_u.send(9'h000, 1'b0, 1'b0);
		ck(STATUS_OFS, 8'h22, 8'h22);
		ck(DATA_OFS, 8'hff, 8'h00);
		ck(STATUS_OFS, 8'h02, 8'h00);
		peer_u.send(9'h0f0, 1'b1, 1'b1);
		ck(STATUS_OFS, 8'h24, 8'h24);
		ck(DATA_OFS, 8'hff, 8'hf0);
		ck(STATUS_OFS, 8'h04, 8'h00);
		wr(CTRL2_OFS, 8'h1c);
		repeat (200) @(posedge core_clk);
		`CHK(irq, 1'b1)
		ck(STATUS_OFS, 8'h10, 8'h10);
	endtask
	task automatic t_toggle_baud();
		int         n;
		int         c;
		logic [7:0] v;
		c = peer_u.got_cnt + 1;
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'h55);
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'h66);
		wr(CTRL2_OFS, 8'h14);
		wr(CTRL2_OFS, 8'h1c);
		@(posedge core_clk);
		ck(STATUS_OFS, 8'h80, 8'h80);
		wait_got(c);
		`CHK(peer_u.got_word, 9'h055)
		hold(1'b1, n);
		`CHK(n, 400)
		wr(BAUD_OFS, 8'h10);
		ck(BAUD_OFS, 8'hff, 8'h10);
		rd(STATUS_OFS, v);
		wr(DATA_OFS, 8'hff);
		hold(1'b0, n);
		`CHK(n > 60 && n < 65, 1'b1)
		peer_u.glitch();
		ck(STATUS_OFS, 8'h20, 8'h00);
		peer_u.send(9'h0a6, 1'b1, 1'b0);
		ck(STATUS_OFS, 8'h24, 8'h24);
		ck(DATA_OFS, 8'hff, 8'ha6);
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		t_reset();
		t_tx();
		t_tx9_break();
		t_rx();
		t_rx_err();
		t_toggle_baud();
		conclude();
	end
endmodule // testbench
`default_nettype wire
